// *** design/clock_tick_divider.sv ***
/*
 * Divides the rising edges of the clock-mode pin down to a one-cycle tick.
 * Assumes the pin level is already synchronous to clk_sys and slower than a quarter of it.
 */
`timescale 1ns/100ps
module clock_tick_divider #(
    parameter int DIVIDE = gp_timer_pkg::CLOCK_DIVIDE
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin_level,
    input wire logic run,
    output logic tick
);

    localparam int DIV_W = $clog2(DIVIDE);

    logic pin_prev_reg;
    logic [DIV_W-1:0] div_reg;
    logic tick_reg;
    logic rise;

    initial begin
        if (DIVIDE < 2) begin
            $error("clock_tick_divider needs a ratio of at least two");
        end
    end

    assign rise = pin_level & ~pin_prev_reg;
    assign tick = tick_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_level;
        end
    end

    // The divider restarts whenever the clock mode stops, so the first second is a whole one.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (!run) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else if (rise && div_reg == DIV_W'(DIVIDE - 1)) begin
            div_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= rise ? div_reg + 1'b1 : div_reg;
            tick_reg <= 1'b0;
        end
    end

endmodule

// *** design/gp_timer_32bit_modes.sv ***
/*
 * General-purpose timer made of two 16-bit halves: 32-bit one-shot/periodic, 32-bit clock
 * and split 16-bit one-shot/periodic operation, with status flags, mask and trigger.
 * Assumes software strobes come as one-cycle pulses synchronous to clk_sys, and that the
 * GPIO port supplies its own pin drive for when the timer function is not selected.
 */
// Notes on behaviour
// - Reset leaves timer idle, counts and loads at 0xffff, prescales at 0x00.
// - Capture pins act as plain GPIO until the alternate-function bit is set.
// - Configuration 0 selects 32-bit one-shot/periodic, 1 selects 32-bit clock.
// - Configuration 0x4 selects split operation with independent halves.
// - In 32-bit configurations only one 32-bit timer exists.
// - A 32-bit load write fills both halves' load registers.
// - The first-half count reads second half above, first half below.
// - 32-bit down-counter mode is chosen by the first half's mode field only.
// - Enabled counter counts down and reloads the concatenated value after zero.
// - One-shot stops and clears its enable; periodic keeps counting.
// - Zero sets the raw time-out flag, held until cleared by software.
// - Unmasked time-out also shows in the masked status.
// - Time-out emits a converter trigger only with trigger enable set.
// - A load write while counting is taken by the counter next cycle.
// - With stall set and clock enable clear, debug halt freezes the count until execution resumes.
// - Clock mode counts up, loaded with one when first selected.
// - The pin clock is divided to a 1 Hz tick advancing the counter.
// - On match the clock count rolls to zero and keeps counting.
// - Match sets the raw flag, masked flag if unmasked; clear bit clears.
// - With clock enable set, the clock count ignores debug halt and stall.
`timescale 1ns/100ps
module gp_timer_32bit_modes #(
    parameter int CLOCK_DIVIDE = gp_timer_pkg::CLOCK_DIVIDE
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic config_wr,
    input wire logic [2:0] config_wdata,
    input wire logic first_half_mode_wr,
    input wire logic [1:0] first_half_mode_wdata,
    input wire logic second_half_mode_wr,
    input wire logic [1:0] second_half_mode_wdata,
    input wire logic control_wr,
    input wire logic [15:0] control_wdata,
    input wire logic first_half_load_wr,
    input wire logic [31:0] first_half_load_wdata,
    input wire logic second_half_load_wr,
    input wire logic [15:0] second_half_load_wdata,
    input wire logic first_half_match_wr,
    input wire logic [31:0] first_half_match_wdata,
    input wire logic first_half_prescale_wr,
    input wire logic [7:0] first_half_prescale_wdata,
    input wire logic second_half_prescale_wr,
    input wire logic [7:0] second_half_prescale_wdata,
    input wire logic mask_wr,
    input wire logic [2:0] mask_wdata,
    input wire logic clear_wr,
    input wire logic [2:0] clear_wdata,
    input wire logic debug_halt,
    input wire logic alt_function_select_bit,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic capture_pin_0_in,
    output logic capture_pin_0_out,
    output logic capture_pin_0_oe,
    output logic gpio_in,
    output logic [2:0] timer_config_reg,
    output logic [1:0] first_half_mode_reg,
    output logic [1:0] second_half_mode_reg,
    output logic [15:0] timer_control_reg,
    output logic [31:0] first_half_count_reg,
    output logic [15:0] second_half_count_reg,
    output logic [31:0] first_half_load_reg,
    output logic [15:0] second_half_load_reg,
    output logic [31:0] first_half_match_reg,
    output logic [7:0] first_half_prescale_reg,
    output logic [7:0] second_half_prescale_reg,
    output logic [2:0] raw_status_reg,
    output logic [2:0] interrupt_mask_reg,
    output logic [2:0] masked_status_reg,
    output logic adc_trigger,
    output logic timer_irq
);

    initial begin
        if (CLOCK_DIVIDE < 2) begin
            $error("gp_timer_32bit_modes needs a clock divide ratio of at least two");
        end
    end

    // Per-half storage; index 0 is the first half, index 1 the second.
    logic [15:0] count_reg [2];
    logic [15:0] load_reg [2];
    logic [1:0] mode_reg [2];
    logic [2:0] config_reg;
    logic [15:0] control_reg;
    logic [31:0] match_reg;
    logic [7:0] prescale_reg [2];
    logic [2:0] raw_reg;
    logic [2:0] mask_reg;
    logic clock_seen_reg;
    logic trigger_reg;

    logic is_timer32;
    logic is_clock32;
    logic is_split;
    logic [31:0] count32;
    logic [31:0] load32;
    logic run32;
    logic timeout32;
    logic clock_run;
    logic clock_tick;
    logic clock_step;
    logic clock_hit;
    logic first_clock_select;
    logic timer_pin;
    logic [1:0] en;
    logic [1:0] stall;
    logic [1:0] trig_en;
    logic [1:0] run16;
    logic [1:0] timeout16;

    assign is_timer32 = config_reg == gp_timer_pkg::CFG_32_TIMER;
    assign is_clock32 = config_reg == gp_timer_pkg::CFG_32_CLOCK;
    assign is_split = config_reg == gp_timer_pkg::CFG_16_SPLIT;
    assign count32 = {count_reg[1], count_reg[0]};
    assign load32 = {load_reg[1], load_reg[0]};

    // Pin sharing: the timer neither sees nor drives the pin unless the port hands it over.
    assign timer_pin = alt_function_select_bit & capture_pin_0_in;
    assign gpio_in = capture_pin_0_in;
    assign capture_pin_0_out = alt_function_select_bit ? 1'b0 : gpio_out;
    assign capture_pin_0_oe = alt_function_select_bit ? 1'b0 : gpio_oe;

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            assign en[h] = control_reg[gp_timer_pkg::CTRL_EN + h * gp_timer_pkg::HALF_STRIDE];
            assign trig_en[h] = control_reg[gp_timer_pkg::CTRL_TRIG_EN + h * gp_timer_pkg::HALF_STRIDE];
            // Debug halt freezes a half only while its stall bit is set and the clock enable bit is clear.
            assign stall[h] = debug_halt
                              & control_reg[gp_timer_pkg::CTRL_STALL + h * gp_timer_pkg::HALF_STRIDE]
                              & ~control_reg[gp_timer_pkg::CTRL_CLOCK_EN];
            assign run16[h] = is_split & en[h] & ~stall[h];
            assign timeout16[h] = run16[h] & (count_reg[h] == 16'h0000);
        end
    endgenerate

    // The 32-bit down-counter obeys only the first half's enable, stall and mode.
    assign run32 = is_timer32 & en[0] & ~stall[0];
    assign timeout32 = run32 & (count32 == 32'h0000_0000);

    // Clock mode keeps running through a halt whenever the clock enable bit is set.
    assign clock_run = is_clock32 & en[0] & ~(stall[0] | stall[1]);
    assign clock_step = clock_run & clock_tick;
    assign clock_hit = clock_step & (count32 == match_reg);
    assign first_clock_select = config_wr & (config_wdata == gp_timer_pkg::CFG_32_CLOCK) & ~clock_seen_reg;

    clock_tick_divider #(
        .DIVIDE(CLOCK_DIVIDE)
    ) u_tick (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_level(timer_pin),
        .run(clock_run),
        .tick(clock_tick)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= 3'h0;
            clock_seen_reg <= 1'b0;
        end else if (config_wr) begin
            config_reg <= config_wdata;
            clock_seen_reg <= clock_seen_reg | (config_wdata == gp_timer_pkg::CFG_32_CLOCK);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg[0] <= 2'h0;
            mode_reg[1] <= 2'h0;
        end else begin
            if (first_half_mode_wr) begin
                mode_reg[0] <= first_half_mode_wdata;
            end
            if (second_half_mode_wr) begin
                mode_reg[1] <= second_half_mode_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale_reg[0] <= gp_timer_pkg::PRESCALE_RESET;
            prescale_reg[1] <= gp_timer_pkg::PRESCALE_RESET;
            match_reg <= gp_timer_pkg::MATCH_RESET;
            mask_reg <= 3'h0;
        end else begin
            if (first_half_prescale_wr) begin
                prescale_reg[0] <= first_half_prescale_wdata;
            end
            if (second_half_prescale_wr) begin
                prescale_reg[1] <= second_half_prescale_wdata;
            end
            if (first_half_match_wr) begin
                match_reg <= first_half_match_wdata;
            end
            if (mask_wr) begin
                mask_reg <= mask_wdata;
            end
        end
    end

    // In 32-bit configurations one write fills both load halves.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            load_reg[0] <= gp_timer_pkg::LOAD_RESET;
            load_reg[1] <= gp_timer_pkg::LOAD_RESET;
        end else begin
            if (first_half_load_wr) begin
                load_reg[0] <= first_half_load_wdata[15:0];
            end
            if (first_half_load_wr && !is_split) begin
                load_reg[1] <= first_half_load_wdata[31:16];
            end else if (second_half_load_wr) begin
                load_reg[1] <= second_half_load_wdata;
            end
        end
    end

    // A software control write in the same cycle as a one-shot expiry wins, so a restart is kept.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= gp_timer_pkg::CTRL_RESET;
        end else if (control_wr) begin
            control_reg <= control_wdata & gp_timer_pkg::CTRL_WRITABLE;
        end else begin
            if (timeout32 && mode_reg[0] == gp_timer_pkg::MODE_ONE_SHOT) begin
                control_reg[gp_timer_pkg::CTRL_EN] <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (timeout16[i] && mode_reg[i] == gp_timer_pkg::MODE_ONE_SHOT) begin
                    control_reg[gp_timer_pkg::CTRL_EN + i * gp_timer_pkg::HALF_STRIDE] <= 1'b0;
                end
            end
        end
    end

    // One concern per half pair: the counters, in the view that the configuration selects.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg[0] <= gp_timer_pkg::COUNT_RESET;
            count_reg[1] <= gp_timer_pkg::COUNT_RESET;
        end else if (first_clock_select) begin
            {count_reg[1], count_reg[0]} <= gp_timer_pkg::CLOCK_FIRST_LOAD;
        end else if (is_timer32) begin
            if (first_half_load_wr) begin
                {count_reg[1], count_reg[0]} <= first_half_load_wdata;
            end else if (timeout32) begin
                {count_reg[1], count_reg[0]} <= load32;
            end else if (run32) begin
                {count_reg[1], count_reg[0]} <= count32 - 32'h0000_0001;
            end
        end else if (is_clock32) begin
            if (clock_hit) begin
                {count_reg[1], count_reg[0]} <= gp_timer_pkg::CLOCK_ROLLOVER;
            end else if (clock_step) begin
                {count_reg[1], count_reg[0]} <= count32 + 32'h0000_0001;
            end
        end else if (is_split) begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 && first_half_load_wr) || (i == 1 && second_half_load_wr)) begin
                    count_reg[i] <= (i == 0) ? first_half_load_wdata[15:0] : second_half_load_wdata;
                end else if (timeout16[i]) begin
                    count_reg[i] <= load_reg[i];
                end else if (run16[i]) begin
                    count_reg[i] <= count_reg[i] - 16'h0001;
                end
            end
        end
    end

    // Hardware set wins over a software clear arriving in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw_reg <= 3'h0;
        end else begin
            raw_reg[gp_timer_pkg::STAT_FIRST_TIMEOUT] <= (timeout32 | timeout16[0])
                | (raw_reg[gp_timer_pkg::STAT_FIRST_TIMEOUT]
                   & ~(clear_wr & clear_wdata[gp_timer_pkg::STAT_FIRST_TIMEOUT]));
            raw_reg[gp_timer_pkg::STAT_CLOCK_MATCH] <= clock_hit
                | (raw_reg[gp_timer_pkg::STAT_CLOCK_MATCH]
                   & ~(clear_wr & clear_wdata[gp_timer_pkg::STAT_CLOCK_MATCH]));
            raw_reg[gp_timer_pkg::STAT_SECOND_TIMEOUT] <= timeout16[1]
                | (raw_reg[gp_timer_pkg::STAT_SECOND_TIMEOUT]
                   & ~(clear_wr & clear_wdata[gp_timer_pkg::STAT_SECOND_TIMEOUT]));
        end
    end

    // The trigger is one cycle wide, one cycle after the zero state is seen.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trigger_reg <= 1'b0;
        end else begin
            trigger_reg <= ((timeout32 | timeout16[0]) & trig_en[0]) | (timeout16[1] & trig_en[1]);
        end
    end

    assign timer_config_reg = config_reg;
    assign first_half_mode_reg = mode_reg[0];
    assign second_half_mode_reg = mode_reg[1];
    assign timer_control_reg = control_reg;
    // Split mode shows only the first half; the upper bits then read as zero.
    assign first_half_count_reg = is_split ? {16'h0000, count_reg[0]} : count32;
    assign second_half_count_reg = count_reg[1];
    assign first_half_load_reg = is_split ? {16'h0000, load_reg[0]} : load32;
    assign second_half_load_reg = load_reg[1];
    assign first_half_match_reg = match_reg;
    assign first_half_prescale_reg = prescale_reg[0];
    assign second_half_prescale_reg = prescale_reg[1];
    assign raw_status_reg = raw_reg;
    assign interrupt_mask_reg = mask_reg;
    assign masked_status_reg = raw_reg & mask_reg;
    assign adc_trigger = trigger_reg;
    assign timer_irq = |(raw_reg & mask_reg);

endmodule

// *** design/gp_timer_pkg.sv ***
/*
 * Constants shared by the general-purpose timer: configuration codes, mode field codes,
 * control and status bit positions, reset values and the clock-mode divide ratio.
 * Assumes nothing of its surroundings; it is compiled before every design file.
 */
package gp_timer_pkg;

    // Values written to the configuration register.
    typedef enum logic [2:0] {
        CFG_32_TIMER = 3'h0,
        CFG_32_CLOCK = 3'h1,
        CFG_16_SPLIT = 3'h4
    } config_t;

    localparam int CONFIG_W = 3;

    // Mode field of each half's mode register.
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;

    // Control register layout; the second half's bits sit one stride above the first half's.
    localparam int CTRL_W = 16;
    localparam int CTRL_EN = 0;
    localparam int CTRL_STALL = 1;
    localparam int CTRL_CLOCK_EN = 4;
    localparam int CTRL_TRIG_EN = 5;
    localparam int HALF_STRIDE = 8;
    localparam logic [15:0] CTRL_WRITABLE = 16'h2333;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Raw, mask, masked and clear registers share one layout.
    localparam int STATUS_W = 3;
    localparam int STAT_FIRST_TIMEOUT = 0;
    localparam int STAT_CLOCK_MATCH = 1;
    localparam int STAT_SECOND_TIMEOUT = 2;

    // Reset values, and the clock-mode first-load and rollover values.
    localparam logic [15:0] COUNT_RESET = 16'hffff;
    localparam logic [15:0] LOAD_RESET = 16'hffff;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [31:0] MATCH_RESET = 32'hffff_ffff;
    localparam logic [31:0] CLOCK_FIRST_LOAD = 32'h0000_0001;
    localparam logic [31:0] CLOCK_ROLLOVER = 32'h0000_0000;

    // Pin clock rate and tick rate of the clock mode, in hertz.
    localparam int CLOCK_PIN_HZ = 32768;
    localparam int CLOCK_TICK_HZ = 1;
    localparam int CLOCK_DIVIDE = CLOCK_PIN_HZ / CLOCK_TICK_HZ;

endpackage

// *** verification/clock_pin_source.sv ***
/*
 * Far-side source of the slow clock on the even capture pin.
 * Assumes sampling on clk_sys; the pin stays low while run is low.
 */
`timescale 1ns/100ps
module clock_pin_source #(
    parameter int HALF = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic pin_level
);
    int cnt_reg;

    // Half period of four system cycles keeps the pin below a quarter of the system rate.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 0;
            pin_level <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 0;
            pin_level <= 1'b0;
        end else if (cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            pin_level <= !pin_level;
        end else begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule

// *** verification/gp_timer_32bit_modes_monitor.sv ***
/*
 * Concurrent checks on the ports of the general-purpose timer.
 * Assumes it is bound to the timer's top module and shares its single clock and reset.
 */
`timescale 1ns/100ps
module gp_timer_32bit_modes_monitor #(
    parameter int CLOCK_DIVIDE = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic config_wr,
    input wire logic first_half_mode_wr,
    input wire logic control_wr,
    input wire logic first_half_load_wr,
    input wire logic first_half_match_wr,
    input wire logic clear_wr,
    input wire logic [2:0] clear_wdata,
    input wire logic debug_halt,
    input wire logic alt_function_select_bit,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic capture_pin_0_out,
    input wire logic capture_pin_0_oe,
    input wire logic [2:0] timer_config_reg,
    input wire logic [1:0] first_half_mode_reg,
    input wire logic [15:0] timer_control_reg,
    input wire logic [31:0] first_half_count_reg,
    input wire logic [31:0] first_half_load_reg,
    input wire logic [2:0] raw_status_reg,
    input wire logic [2:0] interrupt_mask_reg,
    input wire logic [2:0] masked_status_reg,
    input wire logic adc_trigger,
    input wire logic timer_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Writes are excluded: only free counting is judged.
    logic timer_run;
    assign timer_run = timer_config_reg == 3'h0 && timer_control_reg[0]
        && !(debug_halt && timer_control_reg[1] && !timer_control_reg[4])
        && !first_half_load_wr && !control_wr && !config_wr && !first_half_mode_wr;

    chk_count_step: assert property (timer_run && first_half_count_reg != 32'h0 |=>
        first_half_count_reg == $past(first_half_count_reg) - 32'h1) else $error("count did not step down");
    chk_zero_reload: assert property (timer_run && first_half_count_reg == 32'h0 |=>
        first_half_count_reg == $past(first_half_load_reg) && raw_status_reg[0]) else $error("no reload at zero");
    chk_one_shot_stop: assert property (timer_run && first_half_count_reg == 32'h0
        && first_half_mode_reg == gp_timer_pkg::MODE_ONE_SHOT |=> !timer_control_reg[0]) else $error("one-shot ran on");
    chk_periodic_runs: assert property (timer_run && first_half_count_reg == 32'h0
        && first_half_mode_reg == gp_timer_pkg::MODE_PERIODIC |=> timer_control_reg[0]) else $error("periodic stopped");
    chk_stall_hold: assert property (timer_config_reg == 3'h0 && debug_halt && timer_control_reg[1]
        && !timer_control_reg[4] && !first_half_load_wr && !control_wr && !config_wr
        |=> $stable(first_half_count_reg)) else $error("count moved in stall");
    chk_raw_sticky: assert property ($fell(raw_status_reg[0]) |->
        $past(clear_wr && clear_wdata[0])) else $error("time-out flag dropped alone");
    chk_trigger_gate: assert property (adc_trigger |->
        $past(timer_control_reg[5]) && raw_status_reg[0]) else $error("trigger without enable");
    chk_masked_and: assert property (masked_status_reg == (raw_status_reg & interrupt_mask_reg))
        else $error("masked status wrong");
    chk_irq_level: assert property (timer_irq == |masked_status_reg)
        else $error("interrupt level wrong");
    chk_pin_share: assert property (capture_pin_0_oe == (!alt_function_select_bit && gpio_oe)
        && (alt_function_select_bit || capture_pin_0_out == gpio_out)) else $error("pin sharing wrong");
    chk_clock_step: assert property (timer_config_reg == 3'h1 && $changed(first_half_count_reg)
        && $past(timer_config_reg == 3'h1 && !first_half_match_wr && !first_half_load_wr && !config_wr)
        |-> first_half_count_reg == $past(first_half_count_reg) + 32'h1 || first_half_count_reg == 32'h0)
        else $error("clock count jumped");
    chk_clock_roll: assert property ($rose(raw_status_reg[1]) |-> first_half_count_reg == 32'h0)
        else $error("match without rollover");
endmodule

// *** verification/test_gp_timer_32bit_modes.sv ***
/*
 * Self-checking bench for the general-purpose timer: reset, one-shot, periodic, stall and clock mode.
 * Assumes the design package is compiled first; inputs change on the falling clock edge.
 */
`timescale 1ns/100ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end

module test_gp_timer_32bit_modes;
    logic clk_sys = 0, rst_n = 0, config_wr = 0, first_half_mode_wr = 0, second_half_mode_wr = 0;
    logic control_wr = 0, first_half_load_wr = 0, second_half_load_wr = 0, first_half_match_wr = 0;
    logic first_half_prescale_wr = 0, second_half_prescale_wr = 0, mask_wr = 0, clear_wr = 0;
    logic debug_halt = 0, alt_function_select_bit = 0, gpio_out = 0, gpio_oe = 0, pin_run = 0, pin_level;
    logic [2:0] config_wdata = 0, mask_wdata = 0, clear_wdata = 0, timer_config_reg;
    logic [1:0] first_half_mode_wdata = 0, second_half_mode_wdata = 0, first_half_mode_reg, second_half_mode_reg;
    logic [15:0] control_wdata = 0, second_half_load_wdata = 0, timer_control_reg;
    logic [31:0] first_half_load_wdata = 0, first_half_match_wdata = 0, first_half_count_reg, first_half_load_reg;
    logic [7:0] first_half_prescale_wdata = 0, second_half_prescale_wdata = 0;
    logic [7:0] first_half_prescale_reg, second_half_prescale_reg;
    logic [15:0] second_half_count_reg, second_half_load_reg;
    logic [31:0] first_half_match_reg, held;
    logic [2:0] raw_status_reg, interrupt_mask_reg, masked_status_reg;
    logic capture_pin_0_out, capture_pin_0_oe, gpio_in, adc_trigger, timer_irq;
    int n_fail = 0, tests_run = 0, i;

    gp_timer_32bit_modes #(.CLOCK_DIVIDE(4)) dut (.capture_pin_0_in(pin_level), .*);
    clock_pin_source src (.clk_sys(clk_sys), .rst_n(rst_n), .run(pin_run), .pin_level(pin_level));

    initial begin
        forever #5 clk_sys = !clk_sys;
    end
    task automatic strobe(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task check_reset;
        `CHECK({timer_config_reg, timer_control_reg}, 19'h0)
        `CHECK({first_half_count_reg, second_half_count_reg}, 48'hffff_ffff_ffff)
        `CHECK({first_half_load_reg, second_half_load_reg}, 48'hffff_ffff_ffff)
        `CHECK({first_half_prescale_reg, second_half_prescale_reg}, 16'h0000)
        gpio_out = 1'b1;
        gpio_oe = 1'b1;
        #1 `CHECK({capture_pin_0_out, capture_pin_0_oe, gpio_in}, 3'b110)
        alt_function_select_bit = 1'b1;
        #1 `CHECK(capture_pin_0_oe, 1'b0)
        alt_function_select_bit = 1'b0;
        @(negedge clk_sys);
    endtask

    task one_shot;
        config_wdata = 3'h0;
        strobe(config_wr);
        first_half_mode_wdata = gp_timer_pkg::MODE_ONE_SHOT;
        strobe(first_half_mode_wr);
        first_half_load_wdata = 32'h0000_0003;
        strobe(first_half_load_wr);
        control_wdata = 16'h0021;
        strobe(control_wr);
        repeat (3) @(negedge clk_sys);
        `CHECK(first_half_count_reg, 32'h0000_0000)
        @(negedge clk_sys);
        `CHECK({first_half_count_reg, raw_status_reg[0], adc_trigger}, {32'h3, 2'b11})
        `CHECK(timer_control_reg[0], 1'b0)
        repeat (3) @(negedge clk_sys);
        `CHECK({first_half_count_reg, raw_status_reg[0], timer_irq}, {32'h3, 2'b10})
        mask_wdata = 3'h1;
        strobe(mask_wr);
        `CHECK({masked_status_reg, timer_irq}, 4'h3)
        clear_wdata = 3'h1;
        strobe(clear_wr);
        `CHECK({raw_status_reg[0], timer_irq}, 2'b00)
    endtask

    task periodic;
        // Second-half mode must be ignored in 32-bit modes.
        second_half_mode_wdata = gp_timer_pkg::MODE_ONE_SHOT;
        strobe(second_half_mode_wr);
        first_half_mode_wdata = gp_timer_pkg::MODE_PERIODIC;
        strobe(first_half_mode_wr);
        first_half_load_wdata = 32'h0002_0000;
        strobe(first_half_load_wr);
        `CHECK({second_half_load_reg, second_half_count_reg}, 32'h0002_0002)
        control_wdata = 16'h0001;
        strobe(control_wr);
        @(negedge clk_sys);
        `CHECK({first_half_count_reg, second_half_count_reg}, 48'h0001_ffff_0001)
        first_half_load_wdata = 32'h0000_0005;
        strobe(first_half_load_wr);
        `CHECK(first_half_count_reg, 32'h5)
        repeat (6) @(negedge clk_sys);
        `CHECK({first_half_count_reg, adc_trigger, timer_control_reg[0]}, {32'h5, 2'b01})
        control_wdata = 16'h0003;
        strobe(control_wr);
        debug_halt = 1'b1;
        held = first_half_count_reg;
        repeat (4) @(negedge clk_sys);
        `CHECK(first_half_count_reg, held)
        debug_halt = 1'b0;
        @(negedge clk_sys);
        `CHECK(first_half_count_reg, held - 32'h1)
        control_wdata = 16'h0000;
        strobe(control_wr);
        clear_wdata = 3'h1;
        strobe(clear_wr);
    endtask

    task clock_mode;
        config_wdata = 3'h1;
        strobe(config_wr);
        `CHECK(first_half_count_reg, 32'h1)
        first_half_match_wdata = 32'h0000_0003;
        strobe(first_half_match_wr);
        mask_wdata = 3'h2;
        strobe(mask_wr);
        alt_function_select_bit = 1'b1;
        debug_halt = 1'b1;
        pin_run = 1'b1;
        control_wdata = 16'h0013;
        strobe(control_wr);
        for (i = 0; i < 400 && raw_status_reg[1] !== 1'b1; i++)
            @(negedge clk_sys);
        // Three ticks of 32 cycles each: about 96.
        `CHECK(i >= 80 && i <= 120, 1'b1)
        `CHECK({first_half_count_reg, masked_status_reg[1], timer_irq}, {32'h0, 2'b11})
        for (i = 0; i < 60 && first_half_count_reg !== 32'h1; i++)
            @(negedge clk_sys);
        `CHECK(first_half_count_reg, 32'h1)
        clear_wdata = 3'h2;
        strobe(clear_wr);
        `CHECK({raw_status_reg[1], timer_irq}, 2'b00)
        pin_run = 1'b0;
        debug_halt = 1'b0;
    endtask

    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        check_reset;
        one_shot;
        periodic;
        clock_mode;
        print_verdict;
    end

    initial begin
        #100us;
        n_fail++;
        print_verdict;
    end
endmodule

bind gp_timer_32bit_modes gp_timer_32bit_modes_monitor #(.CLOCK_DIVIDE(CLOCK_DIVIDE)) mon (.*);
